// File: design/pic_pkg.sv
package pic_pkg;

  // =========================================================
  // special-function addresses
  localparam logic [7:0]  PIC_ADDR_ENABLE_LOW  = 8'h3A;
  localparam logic [7:0]  PIC_ADDR_ENABLE_HIGH = 8'h3B;
  localparam logic [7:0]  PIC_ADDR_LATCH_LOW   = 8'h3C;
  localparam logic [7:0]  PIC_ADDR_LATCH_HIGH  = 8'h3D;
  localparam logic [7:0]  PIC_ADDR_SELECTOR    = 8'h3E;

  // =========================================================
  // field positions and levels
  localparam int          PIC_NUM_LEVELS       = 16;
  localparam int          PIC_IMF_BIT          = 0;
  localparam int          PIC_PICK_BIT         = 1;
  localparam int          PIC_IDX_SOFT         = 1;
  localparam int          PIC_IDX_FETCH        = 2;
  localparam int          PIC_IDX_WDOG         = 3;
  localparam int          PIC_IDX_PIN_A        = 4;
  localparam int          PIC_IDX_SHARED       = 14;
  localparam logic [3:0]  PIC_FIRST_MASKABLE   = 4'h4;
  localparam logic [3:0]  PIC_FIRST_LATCHED    = 4'h2;
  localparam logic [15:0] PIC_VECTOR_TOP       = 16'hFFFE;
  localparam logic [15:0] PIC_LATCH_IMPL       = 16'hFFFC;
  localparam logic [15:0] PIC_EF_IMPL          = 16'hFFF0;

  // =========================================================
  // values after reset
  localparam logic [15:0] PIC_LATCH_RST        = 16'h0000;
  localparam logic [15:0] PIC_EF_RST           = 16'h0000;
  localparam logic        PIC_IMF_RST          = 1'h0;
  localparam logic        PIC_PICK_RST         = 1'h0;
  localparam logic [7:0]  PIC_RDATA_RST        = 8'h00;

  // =========================================================
  // carriers
  typedef struct packed {
    logic ext_pin_e;
    logic timer_three_event;
    logic ext_pin_d;
    logic converter_done_event;
    logic timer_four_event;
    logic serial_port_event;
    logic timer_one_event;
    logic ext_pin_c;
    logic time_base_tick;
    logic ext_pin_b;
    logic ext_pin_a;
    logic watchdog_trap;
    logic fetch_guard_trap;
  } pic_evt_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pic_sfr_s;

  typedef struct packed {
    logic        req;
    logic [3:0]  level;
    logic [15:0] vector;
  } pic_irq_s;

endpackage

// File: design/pic_ctrl.sv
// Functional notes
// - fifteen sources besides reset; four internal non-maskable, rest maskable.
// - a source event sets its request latch to one.
// - a set latch is presented only while its interrupt is enabled.
// - maskable sources need master enable and own enable both one.
// - nesting allowed once software sets master enable inside a routine.
// - simultaneous requests accepted by fixed order, lower level wins.
// - software and illegal-opcode traps: no latch, vector FFFC, level 1.
// - fetch-guard trap: latch bit 2, vector FFFA, non-maskable.
// - watchdog trap: latch bit 3, vector FFF8, non-maskable.
// - pin A: bit 4, vector FFF6, needs master, enable and pin gate.
// - bits 4 to 15 step vectors down by two, level is n.
// - bit 14 shared by pin D and timer three, chosen by pick bit.
// - fetch-guard event requests reset until trap action select is zero.
// - watchdog event requests reset until watchdog action select is zero.
// - a latch is cleared when its interrupt is accepted.
// - all request latches are zero during reset.
// - latches readable as two bytes at 3C low and 3D high.
// - writing zero clears a latch bit; reads give pending status.
// - writing one never sets a latch.
// - acceptance clears master enable.
// - master enable saved on acceptance, restored by interrupt return.
// - master enable is bit 0 of the enable low byte at 3A.
// - the unselected shared source is ignored, not latched.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int NEST_DEPTH = 8
) (
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  input  wire pic_sfr_s sfr,
  input  wire pic_evt_s events,
  input  wire logic     software_trap,
  input  wire logic     illegal_opcode_trap,
  input  wire logic     ext_pin_a_gate,
  input  wire logic     trap_action_select,
  input  wire logic     watchdog_action_select,
  input  wire logic     irq_accept,
  input  wire logic     irq_return_op,
  output var  logic [7:0] sfr_rdata_r,
  output var  pic_irq_s irq_r,
  output var  logic     master_irq_enable_r,
  output var  logic     reset_request_r
);

  // =========================================================
  // state
  logic [15:0]           request_latch_r;
  logic [15:0]           per_source_enable_r;
  logic                  shared_level_pick_r;
  logic [NEST_DEPTH-1:0] imf_stack_r;

  // =========================================================
  // register decode
  wire wr_en_low  = sfr.wr && (sfr.addr == PIC_ADDR_ENABLE_LOW);
  wire wr_en_high = sfr.wr && (sfr.addr == PIC_ADDR_ENABLE_HIGH);
  wire wr_il_low  = sfr.wr && (sfr.addr == PIC_ADDR_LATCH_LOW);
  wire wr_il_high = sfr.wr && (sfr.addr == PIC_ADDR_LATCH_HIGH);
  wire wr_sel     = sfr.wr && (sfr.addr == PIC_ADDR_SELECTOR);

  // =========================================================
  // event capture
  wire fetch_set = events.fetch_guard_trap && !trap_action_select;
  wire wdog_set  = events.watchdog_trap && !watchdog_action_select;
  wire shared_set = shared_level_pick_r ? events.timer_three_event
                                        : events.ext_pin_d;
  wire reset_req_nxt = (events.fetch_guard_trap && trap_action_select) ||
                       (events.watchdog_trap && watchdog_action_select);

  // reserved levels 10 and 12 have no source
  wire [15:0] set_vec = {events.ext_pin_e, shared_set,
                         events.converter_done_event, 1'h0,
                         events.timer_four_event, 1'h0,
                         events.serial_port_event, events.timer_one_event,
                         events.ext_pin_c, events.time_base_tick,
                         events.ext_pin_b, events.ext_pin_a,
                         wdog_set, fetch_set, 2'h0};

  // =========================================================
  // latch clearing
  wire [7:0]  clr_low  = wr_il_low  ? ~sfr.wdata : 8'h00;
  wire [7:0]  clr_high = wr_il_high ? ~sfr.wdata : 8'h00;
  wire [15:0] wr_clr   = {clr_high, clr_low} & PIC_LATCH_IMPL;
  wire [15:0] acc_clr  = irq_accept ?
                         ((16'h0001 << irq_r.level) & PIC_LATCH_IMPL)
                         : 16'h0000;

  // set wins over any clear; writing one only keeps the bit
  wire [15:0] latch_nxt = (request_latch_r & ~wr_clr & ~acc_clr) |
                          set_vec;

  // =========================================================
  // enables and candidates
  logic [15:0] level_en;
  genvar n;
  generate
    for (n = 0; n < PIC_NUM_LEVELS; n++) begin : g_en
      if (n < PIC_IDX_FETCH) begin : g_none
        assign level_en[n] = 1'h0;
      end else if (n < PIC_IDX_PIN_A) begin : g_nmi
        assign level_en[n] = 1'h1;
      end else if (n == PIC_IDX_PIN_A) begin : g_pin_a
        assign level_en[n] = master_irq_enable_r &&
                             per_source_enable_r[n] && ext_pin_a_gate;
      end else begin : g_mask
        assign level_en[n] = master_irq_enable_r &&
                             per_source_enable_r[n];
      end
    end
  endgenerate

  wire        soft_req = software_trap || illegal_opcode_trap;
  wire [15:0] cand = (request_latch_r & level_en) |
                     (soft_req ? 16'h0002 : 16'h0000);
  wire [15:0] first_hot = cand & (~cand + 16'h0001);

  function automatic logic [3:0] pic_encode(input logic [15:0] hot);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < PIC_NUM_LEVELS; i++) begin
      if (hot[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  wire [3:0]  win_level  = pic_encode(first_hot);
  wire [15:0] win_vector = PIC_VECTOR_TOP -
                           {11'h000, win_level, 1'h0};
  // the stale request is dropped in the cycle after an acceptance
  pic_irq_s irq_nxt;
  assign irq_nxt = '{req:    (cand != 16'h0000) && !irq_accept,
                     level:  win_level,
                     vector: win_vector};

  // =========================================================
  // master enable with nesting stack
  wire wr_imf = wr_en_low;
  logic                  imf_nxt;
  logic [NEST_DEPTH-1:0] stack_nxt;
  assign imf_nxt = irq_accept    ? 1'h0 :
                   irq_return_op ? imf_stack_r[0] :
                   wr_imf        ? sfr.wdata[PIC_IMF_BIT] :
                                   master_irq_enable_r;
  assign stack_nxt = irq_accept ?
                     {imf_stack_r[NEST_DEPTH-2:0], master_irq_enable_r} :
                     irq_return_op ? {1'h0, imf_stack_r[NEST_DEPTH-1:1]} :
                     imf_stack_r;

  wire [15:0] ef_nxt = {wr_en_high ? sfr.wdata : per_source_enable_r[15:8],
                        wr_en_low ? sfr.wdata[7:4]
                                  : per_source_enable_r[7:4],
                        4'h0} & PIC_EF_IMPL;
  wire pick_nxt = wr_sel ? sfr.wdata[PIC_PICK_BIT] : shared_level_pick_r;

  // =========================================================
  // read mux
  wire [7:0] rd_mux =
    (sfr.addr == PIC_ADDR_ENABLE_LOW)  ?
      {per_source_enable_r[7:4], 3'h0, master_irq_enable_r} :
    (sfr.addr == PIC_ADDR_ENABLE_HIGH) ? per_source_enable_r[15:8] :
    (sfr.addr == PIC_ADDR_LATCH_LOW)   ? request_latch_r[7:0] :
    (sfr.addr == PIC_ADDR_LATCH_HIGH)  ? request_latch_r[15:8] :
    (sfr.addr == PIC_ADDR_SELECTOR)    ? {6'h00, shared_level_pick_r, 1'h0} :
                                         8'h00;
  wire [7:0] rdata_nxt = sfr.rd ? rd_mux : sfr_rdata_r;

  // =========================================================
  // flip-flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_latch_r <= PIC_LATCH_RST;
      per_source_enable_r <= PIC_EF_RST;
      shared_level_pick_r <= PIC_PICK_RST;
      master_irq_enable_r <= PIC_IMF_RST;
      imf_stack_r <= '0;
      irq_r <= '0;
      sfr_rdata_r <= PIC_RDATA_RST;
      reset_request_r <= 1'h0;
    end else begin
      request_latch_r <= latch_nxt;
      per_source_enable_r <= ef_nxt;
      shared_level_pick_r <= pick_nxt;
      master_irq_enable_r <= imf_nxt;
      imf_stack_r <= stack_nxt;
      irq_r <= irq_nxt;
      sfr_rdata_r <= rdata_nxt;
      reset_request_r <= reset_req_nxt;
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_acc_on;
    irq_accept && master_irq_enable_r && !irq_return_op;
  endsequence

  sequence s_ret;
    irq_return_op && !irq_accept && !wr_imf;
  endsequence

  sequence s_quiet;
    !irq_accept && !irq_return_op;
  endsequence

  accept_clears_a: assert property (
    (acc_clr != 16'h0000) && ((acc_clr & set_vec) == 16'h0000)
    |=> ((request_latch_r & $past(acc_clr)) == 16'h0000))
    else $error("accepted latch not cleared");

  write_no_set_a: assert property (
    (set_vec == 16'h0000)
    |=> ((request_latch_r & ~$past(request_latch_r)) == 16'h0000))
    else $error("latch set without event");

  event_sets_a: assert property (
    (set_vec != 16'h0000)
    |=> ((request_latch_r & $past(set_vec)) == $past(set_vec)))
    else $error("event did not set latch");

  set_wins_a: assert property (
    ((set_vec & wr_clr) != 16'h0000)
    |=> ((request_latch_r & $past(set_vec)) == $past(set_vec)))
    else $error("clear beat a new event");

  imf_clear_a: assert property (
    irq_accept |=> !master_irq_enable_r ##0 !irq_r.req)
    else $error("master enable survived acceptance");

  imf_restore_a: assert property (
    (s_acc_on ##1 s_quiet ##1 s_ret) |=> master_irq_enable_r)
    else $error("return did not restore master enable");

  mask_gate_a: assert property (
    irq_r.req && (irq_r.level >= PIC_FIRST_MASKABLE)
    |-> $past(master_irq_enable_r))
    else $error("maskable request with master enable off");

  prio_order_a: assert property (
    irq_r.req |-> (($past(cand) &
      ((16'h0001 << irq_r.level) - 16'h0001)) == 16'h0000))
    else $error("lower level was pending");

  vector_map_a: assert property (
    irq_r.req && (irq_r.level >= PIC_FIRST_LATCHED)
    |-> (($past(request_latch_r) &
          (16'h0001 << irq_r.level)) != 16'h0000) &&
        (irq_r.vector == PIC_VECTOR_TOP - {11'h000, irq_r.level, 1'h0}))
    else $error("vector does not match level");

  shared_pick_a: assert property (
    events.ext_pin_d && !events.timer_three_event &&
    shared_level_pick_r && !request_latch_r[PIC_IDX_SHARED]
    |=> !request_latch_r[PIC_IDX_SHARED])
    else $error("unselected shared source latched");

  trap_reset_a: assert property (
    events.fetch_guard_trap && trap_action_select &&
    !set_vec[PIC_IDX_FETCH] && !request_latch_r[PIC_IDX_FETCH]
    |=> reset_request_r && !request_latch_r[PIC_IDX_FETCH])
    else $error("fetch guard did not request reset");

  latch_reset_a: assert property (
    $rose(rst_n) |-> (request_latch_r == PIC_LATCH_RST))
    else $error("latches not cleared by reset");

  wdog_reset_a: assert property (
    events.watchdog_trap && watchdog_action_select &&
    !request_latch_r[PIC_IDX_WDOG]
    |=> reset_request_r && !request_latch_r[PIC_IDX_WDOG])
    else $error("watchdog did not request reset");

  pin_gate_a: assert property (
    irq_r.req && (irq_r.level == PIC_IDX_PIN_A)
    |-> $past(ext_pin_a_gate) && $past(per_source_enable_r[PIC_IDX_PIN_A]))
    else $error("pin A presented without its gates");

  soft_vector_a: assert property (
    irq_r.req && (irq_r.level == PIC_IDX_SOFT)
    |-> $past(soft_req) && (irq_r.vector == PIC_VECTOR_TOP - 16'h0002))
    else $error("software trap vector wrong");

  fetch_shown_a: assert property (
    request_latch_r[PIC_IDX_FETCH] && !irq_accept
    |=> irq_r.req && (irq_r.level <= PIC_IDX_FETCH))
    else $error("fetch guard request not presented");

  masked_hold_a: assert property (
    !master_irq_enable_r && !soft_req &&
    (request_latch_r[PIC_IDX_WDOG:PIC_IDX_FETCH] == 2'h0)
    |=> !irq_r.req)
    else $error("masked request presented");

  latch_read_a: assert property (
    sfr.rd && (sfr.addr == PIC_ADDR_LATCH_HIGH)
    |=> (sfr_rdata_r == $past(request_latch_r[15:8])))
    else $error("high latch byte read wrong");

  clear_write_a: assert property (
    ((wr_clr & ~set_vec) != 16'h0000)
    |=> ((request_latch_r & $past(wr_clr & ~set_vec)) == 16'h0000))
    else $error("written zero did not clear latch");

endmodule
`default_nettype wire

// File: dv/pic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model
  import pic_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire pic_irq_s    irq,
  input  wire logic        take_en,
  input  wire logic [2:0]  take_delay,
  output var  logic        irq_accept,
  output var  logic [3:0]  taken_level_r,
  output var  logic [15:0] taken_vector_r,
  output var  logic [7:0]  taken_cnt_r
);
  // ========
  // accept a presented request after take_delay cycles
  logic [2:0] wait_r;
  wire        go = take_en && irq.req && !irq_accept;
  wire        due = go && (wait_r == take_delay);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_accept     <= 1'h0;
      wait_r         <= 3'h0;
      taken_level_r  <= 4'h0;
      taken_vector_r <= 16'h0000;
      taken_cnt_r    <= 8'h00;
    end else begin
      irq_accept <= due;
      wait_r     <= (go && !due) ? wait_r + 3'h1 : 3'h0;
      if (irq_accept) begin
        taken_level_r  <= irq.level;
        taken_vector_r <= irq.vector;
        taken_cnt_r    <= taken_cnt_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_pic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pic_ctrl
  import pic_pkg::*;
;
  logic        sys_clk;
  logic        rst_n;
  pic_sfr_s    sfr;
  pic_evt_s    ev;
  logic [1:0]  traps;
  logic        pin_gate;
  logic [1:0]  act_sel;
  logic        ret_op;
  logic        take_en;
  logic [2:0]  take_delay;
  logic        irq_accept;
  logic [7:0]  rdata;
  pic_irq_s    irq;
  logic        master_irq_enable;
  logic        rst_req;
  logic [3:0]  t_lvl;
  logic [15:0] t_vec;
  logic [7:0]  t_cnt;
  int          num_errors;
  int          comparisons;
  // row: pick, event bit, level
  logic [8:0]  rows [13] = '{9'h002, 9'h013, 9'h024, 9'h035, 9'h046,
    9'h057, 9'h068, 9'h079, 9'h08B, 9'h09D, 9'h0AE, 9'h1BE, 9'h0CF};

  pic_ctrl #(.NEST_DEPTH(8)) pic_ctrl_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .sfr(sfr), .events(ev), .software_trap(traps[0]),
    .illegal_opcode_trap(traps[1]), .ext_pin_a_gate(pin_gate),
    .trap_action_select(act_sel[0]), .watchdog_action_select(act_sel[1]),
    .irq_accept(irq_accept), .irq_return_op(ret_op), .sfr_rdata_r(rdata),
    .irq_r(irq), .master_irq_enable_r(master_irq_enable), .reset_request_r(rst_req));
  pic_cpu_model pic_cpu_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .irq(irq), .take_en(take_en), .take_delay(take_delay),
    .irq_accept(irq_accept), .taken_level_r(t_lvl),
    .taken_vector_r(t_vec), .taken_cnt_r(t_cnt));

  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ========
  // helpers
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr <= '{addr: a, wr: 1'h1, rd: 1'h0, wdata: d};
    @(posedge sys_clk);
    sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfr <= '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
    @(posedge sys_clk);
    sfr <= '0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic pulse(input logic [3:0] b);
    @(posedge sys_clk);
    ev <= pic_evt_s'(13'h0001 << b);
    @(posedge sys_clk);
    ev <= '0;
  endtask
  task automatic settle(input logic [15:0] lvl);
    repeat (2) @(posedge sys_clk);
    #1 chk("req", lvl, irq.req ? {12'h000, irq.level} : 16'h0000);
  endtask
  task automatic wait_taken();
    logic [7:0] c0;
    c0 = t_cnt;
    for (int k = 0; k < 40 && t_cnt == c0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (t_cnt == c0) begin
      $display("MISMATCH accept expected 1 seen 0");
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic ret();
    @(posedge sys_clk);
    ret_op <= 1'h1;
    @(posedge sys_clk);
    ret_op <= 1'h0;
    #1;
  endtask

  // ========
  // main sequence
  initial begin
    rst_n = 1'h0; sfr = '0; ev = '0; traps = 2'h0; pin_gate = 1'h0;
    act_sel = 2'h3; ret_op = 1'h0; take_en = 1'h0; take_delay = 3'h0;
    num_errors = 0; comparisons = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int a = 8'h3A; a <= 8'h3E; a++) rd(8'(a), 8'h00);
    $display("test reset done");
    @(posedge sys_clk); act_sel <= 2'h0; pin_gate <= 1'h1; take_en <= 1'h1;
    wr(PIC_ADDR_ENABLE_HIGH, 8'hFF);
    wr(PIC_ADDR_ENABLE_LOW, 8'hF1);
    rd(PIC_ADDR_ENABLE_LOW, 8'hF1);
    for (int i = 0; i < 13; i++) begin
      take_delay <= 3'(i);
      wr(PIC_ADDR_SELECTOR, {6'h00, rows[i][8], 1'h0});
      pulse(rows[i][7:4]);
      wait_taken();
      chk("level", {12'h000, rows[i][3:0]}, {12'h000, t_lvl});
      chk("vector", 16'hFFFE - {11'h000, rows[i][3:0], 1'h0}, t_vec);
      chk("master", 16'h0000, {15'h0000, master_irq_enable});
      rd(PIC_ADDR_LATCH_LOW, 8'h00);
      rd(PIC_ADDR_LATCH_HIGH, 8'h00);
      ret();
      chk("master", 16'h0001, {15'h0000, master_irq_enable});
    end
    $display("test sources done");
    @(posedge sys_clk); take_en <= 1'h0; take_delay <= 3'h0;
    @(posedge sys_clk); ev <= pic_evt_s'(13'h0088);
    @(posedge sys_clk); ev <= '0;
    settle(16'h0005);
    @(posedge sys_clk); take_en <= 1'h1;
    wait_taken();
    chk("taken", 16'h0005, {12'h000, t_lvl});
    wr(PIC_ADDR_ENABLE_LOW, 8'hF1);
    wait_taken();
    chk("taken", 16'h0009, {12'h000, t_lvl});
    ret();
    ret();
    chk("master", 16'h0001, {15'h0000, master_irq_enable});
    $display("test priority done");
    @(posedge sys_clk); take_en <= 1'h0;
    wr(PIC_ADDR_ENABLE_LOW, 8'hF0);
    pulse(4'h5);
    settle(16'h0000);
    rd(PIC_ADDR_LATCH_LOW, 8'h80);
    wr(PIC_ADDR_ENABLE_LOW, 8'h71);
    settle(16'h0000);
    wr(PIC_ADDR_LATCH_LOW, 8'h7F);
    rd(PIC_ADDR_LATCH_LOW, 8'h00);
    wr(PIC_ADDR_LATCH_HIGH, 8'hFF);
    rd(PIC_ADDR_LATCH_HIGH, 8'h00);
    @(posedge sys_clk); ev <= pic_evt_s'(13'h0020);
    sfr <= '{addr: PIC_ADDR_LATCH_LOW, wr: 1'h1, rd: 1'h0, wdata: 8'h0C};
    @(posedge sys_clk); ev <= '0; sfr <= '0;
    rd(PIC_ADDR_LATCH_LOW, 8'h80);
    wr(PIC_ADDR_LATCH_LOW, 8'h0C);
    for (int k = 0; k < 2; k++) begin
      wr(PIC_ADDR_SELECTOR, k ? 8'h02 : 8'h00);
      pulse(k ? 4'hA : 4'hB);
      rd(PIC_ADDR_LATCH_HIGH, 8'h00);
    end
    $display("test latch access done");
    @(posedge sys_clk); pin_gate <= 1'h0;
    wr(PIC_ADDR_ENABLE_LOW, 8'hF1);
    pulse(4'h2);
    settle(16'h0000);
    rd(PIC_ADDR_LATCH_LOW, 8'h10);
    wr(PIC_ADDR_ENABLE_LOW, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk); traps <= 2'(1 << k);
      settle(16'h0001);
      chk("vector", 16'hFFFC, irq.vector);
      @(posedge sys_clk); take_en <= 1'h1;
      wait_taken();
      @(posedge sys_clk); traps <= 2'h0; take_en <= 1'h0;
      ret();
    end
    @(posedge sys_clk); act_sel <= 2'h3;
    for (int k = 0; k < 2; k++) begin
      pulse(4'(k));
      #1 chk("reset_req", 16'h0001, {15'h0000, rst_req});
    end
    rd(PIC_ADDR_LATCH_LOW, 8'h10);
    $display("test traps done");
    @(posedge sys_clk); rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(PIC_ADDR_LATCH_LOW, 8'h00);
    $display("test mid reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
